/* core/ccr_pkg.sv */
// Constants for the condition-code flag and alignment block.
// Assumes a single 100 MHz clock and asynchronous active-low reset.
package ccr_pkg;
    // ************
    // Flag register layout
    // ************
    localparam int CCR_WIDTH    = 8;
    localparam int BIT_MASK     = 7;
    localparam int BIT_UI       = 6;
    localparam int BIT_HALF     = 5;
    localparam int BIT_U        = 4;
    localparam int BIT_NEG      = 3;
    localparam int BIT_ZERO     = 2;
    localparam int BIT_OVF      = 1;
    localparam int BIT_CARRY    = 0;
    localparam logic MASK_RESET = 1'h1;
    localparam logic TRACE_RESET = 1'h0;
    localparam logic [2:0] EXR_MASK_RESET = 3'h7;
    localparam logic [3:0] EXR_RSVD = 4'hf;
    localparam int EXR_BIT_TRACE = 7;
    // Half-carry positions per size
    localparam int HC_BYTE = 3;
    localparam int HC_WORD = 11;
    localparam int HC_LONG = 27;
    localparam int PC_WIDTH = 24;
    localparam int ADDR_WIDTH = 32;

    // ************
    // Enumerations
    // ************
    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_WORD = 2'b01,
        SZ_LONG = 2'b10
    } size_type;

    typedef enum logic [3:0] {
        OP_NONE  = 4'b0000,
        OP_ADD   = 4'b0001,
        OP_SUB   = 4'b0010,
        OP_NEG   = 4'b0011,
        OP_LOGIC = 4'b0100,
        OP_SHIFT = 4'b0101,
        OP_BLD   = 4'b0110,
        OP_BAND  = 4'b0111,
        OP_BOR   = 4'b1000,
        OP_BXOR  = 4'b1001,
        OP_LDC   = 4'b1010,
        OP_AND_CONTROL_INSTRUCTION  = 4'b1011,
        OP_ORC   = 4'b1100,
        OP_XOR_CONTROL_INSTRUCTION  = 4'b1101,
        OP_DECADJ = 4'b1110
    } op_type;

    typedef enum logic [1:0] {
        ST_RESET  = 2'b00,
        ST_VECTOR = 2'b01,
        ST_RUN    = 2'b10
    } state_type;
endpackage

/* core/cpu_condition_flags.sv */
// Condition-code flag logic, branch conditions, interrupt gating and
// address alignment. Assumes the decoder gives one operation per cycle.
module cpu_condition_flags
    import ccr_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  arst_n,
    input  wire op_type                opCode,
    input  wire size_type              opSize,
    input  wire logic [31:0]           operandA,
    input  wire logic [31:0]           operandB,
    input  wire logic                  useExtend,
    input  wire logic                  shiftOut,
    input  wire logic [2:0]            bitIndex,
    input  wire logic                  bitInvert,
    input  wire logic [CCR_WIDTH-1:0]  immData,
    input  wire logic                  storeReq,
    input  wire logic [3:0]            branchCond,
    input  wire logic                  irqReq,
    input  wire logic                  nmiReq,
    input  wire logic                  excStart,
    input  wire logic [PC_WIDTH-1:0]   vectorAddr,
    input  wire logic                  vectorValid,
    input  wire logic [PC_WIDTH-1:0]   pcNext,
    input  wire logic                  pcLoad,
    input  wire logic [ADDR_WIDTH-1:0] dataAddr,
    input  wire logic                  dataWide,
    output logic [31:0]                resultData,
    output logic [CCR_WIDTH-1:0]       storeData,
    output logic                       branchTaken,
    output logic                       irqAccept,
    output logic [ADDR_WIDTH-1:0]      busDataAddr,
    output logic [PC_WIDTH-1:0]        fetchAddr,
    output logic                       resetBusy
);
    // ************
    // State
    // ************
    typedef struct packed {
        state_type              phase;
        logic [31:0]            result;
        logic [CCR_WIDTH-1:0]   store;
        logic                   taken;
        logic                   irqOk;
        logic [ADDR_WIDTH-1:0]  dAddr;
        logic [PC_WIDTH-1:0]    pc;
        logic                   busy;
    } regs_type;

    regs_type             state_reg;
    regs_type             state_next;
    logic [CCR_WIDTH-1:0] ccrQ;
    logic [CCR_WIDTH-1:0] exrQ;
    logic                 ccrWe;
    logic [CCR_WIDTH-1:0] ccrWdata;
    logic                 exrWe;
    logic [CCR_WIDTH-1:0] exrWdata;

    flag_store u_store (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .ccrWe    (ccrWe),
        .ccrWdata (ccrWdata),
        .exrWe    (exrWe),
        .exrWdata (exrWdata),
        .ccrQ     (ccrQ),
        .exrQ     (exrQ)
    );

    // ************
    // Helpers
    // ************
    function automatic int msbOf(input size_type sz);
        unique case (sz)
            SZ_BYTE: msbOf = 7;
            SZ_WORD: msbOf = 15;
            default: msbOf = 31;
        endcase
    endfunction

    function automatic int hcOf(input size_type sz);
        unique case (sz)
            SZ_BYTE: hcOf = HC_BYTE;
            SZ_WORD: hcOf = HC_WORD;
            default: hcOf = HC_LONG;
        endcase
    endfunction

    function automatic logic [31:0] maskOf(input size_type sz);
        unique case (sz)
            SZ_BYTE: maskOf = 32'h0000_00ff;
            SZ_WORD: maskOf = 32'h0000_ffff;
            default: maskOf = 32'hffff_ffff;
        endcase
    endfunction

    // ************
    // Datapath
    // ************
    logic [32:0] sum;
    logic [32:0] hsum;
    logic [31:0] aM;
    logic [31:0] bM;
    logic [31:0] res;
    logic        carryIn;
    logic        isSub;
    logic        cond;
    logic        selBit;
    logic [7:0]  adj;
    int          msb;
    int          hc;

    always_comb
    begin
        msb     = msbOf(opSize);
        hc      = hcOf(opSize);
        isSub   = (opCode == OP_SUB) || (opCode == OP_NEG);
        carryIn = useExtend && (opSize == SZ_BYTE) ? ccrQ[BIT_CARRY] : 1'b0;
        aM      = (opCode == OP_NEG) ? 32'h0000_0000 : operandA & maskOf(opSize);
        bM      = operandB & maskOf(opSize);
        // Subtraction done directly, not as add of complement, so half-carry is a borrow
        if (isSub)
            sum = {1'b0, aM} - {1'b0, bM} - {32'h0000_0000, carryIn};
        else
            sum = {1'b0, aM} + {1'b0, bM} + {32'h0000_0000, carryIn};
        hsum = {1'b0, aM & ((32'h0000_0001 << (hc + 1)) - 32'h0000_0001)};
        if (isSub)
            hsum = hsum - {1'b0, bM & ((32'h0000_0001 << (hc + 1)) - 32'h0000_0001)}
                 - {32'h0000_0000, carryIn};
        else
            hsum = hsum + {1'b0, bM & ((32'h0000_0001 << (hc + 1)) - 32'h0000_0001)}
                 + {32'h0000_0000, carryIn};
        res = sum[31:0] & maskOf(opSize);
        // Packed BCD adjust of a byte
        adj = operandA[7:0];
        if (opCode == OP_DECADJ)
        begin
            if (!useExtend)
            begin
                if (ccrQ[BIT_HALF] || adj[3:0] > 4'h9)
                    adj = adj + 8'h06;
                if (ccrQ[BIT_CARRY] || operandA[7:0] > 8'h99)
                    adj = adj + 8'h60;
            end
            else
            begin
                if (ccrQ[BIT_HALF])
                    adj = adj - 8'h06;
                if (ccrQ[BIT_CARRY])
                    adj = adj - 8'h60;
            end
        end
        selBit = operandA[bitIndex] ^ bitInvert;
        unique case (branchCond)
            4'h0: cond = 1'b1;
            4'h1: cond = 1'b0;
            4'h2: cond = !(ccrQ[BIT_CARRY] || ccrQ[BIT_ZERO]);
            4'h3: cond = ccrQ[BIT_CARRY] || ccrQ[BIT_ZERO];
            4'h4: cond = !ccrQ[BIT_CARRY];
            4'h5: cond = ccrQ[BIT_CARRY];
            4'h6: cond = !ccrQ[BIT_ZERO];
            4'h7: cond = ccrQ[BIT_ZERO];
            4'h8: cond = !ccrQ[BIT_OVF];
            4'h9: cond = ccrQ[BIT_OVF];
            4'ha: cond = !ccrQ[BIT_NEG];
            4'hb: cond = ccrQ[BIT_NEG];
            4'hc: cond = ccrQ[BIT_NEG] == ccrQ[BIT_OVF];
            4'hd: cond = ccrQ[BIT_NEG] != ccrQ[BIT_OVF];
            4'he: cond = !ccrQ[BIT_ZERO] && (ccrQ[BIT_NEG] == ccrQ[BIT_OVF]);
            4'hf: cond = ccrQ[BIT_ZERO] || (ccrQ[BIT_NEG] != ccrQ[BIT_OVF]);
        endcase
    end

    // ************
    // Next state
    // ************
    always_comb
    begin
        state_next = state_reg;
        ccrWe      = 1'b0;
        ccrWdata   = ccrQ;
        exrWe      = 1'b0;
        exrWdata   = exrQ;
        state_next.store = storeReq ? ccrQ : state_reg.store;
        state_next.taken = cond;
        state_next.irqOk = nmiReq || (irqReq && !ccrQ[BIT_MASK]);
        // Odd wide data addresses are quietly rounded down
        state_next.dAddr = dataWide ? {dataAddr[ADDR_WIDTH-1:1], 1'b0}
                                    : dataAddr;
        unique case (state_reg.phase)
            ST_RESET:
                state_next.phase = ST_VECTOR;
            ST_VECTOR:
            begin
                if (vectorValid)
                begin
                    state_next.pc    = {vectorAddr[PC_WIDTH-1:1], 1'b0};
                    state_next.phase = ST_RUN;
                    state_next.busy  = 1'b0;
                end
            end
            ST_RUN:
            begin
                if (pcLoad)
                    state_next.pc = {pcNext[PC_WIDTH-1:1], 1'b0};
            end
            default:
                state_next.phase = ST_RESET;
        endcase
        if (state_reg.phase == ST_RUN)
        begin
            unique case (opCode)
                OP_ADD, OP_SUB, OP_NEG:
                begin
                    ccrWe    = 1'b1;
                    ccrWdata[BIT_HALF]  = hsum[hc + 1];
                    ccrWdata[BIT_NEG]   = res[msb];
                    // Extend forms only keep zero once cleared
                    ccrWdata[BIT_ZERO]  = (res == 32'h0000_0000) &&
                                          (!useExtend || ccrQ[BIT_ZERO]);
                    ccrWdata[BIT_OVF]   = isSub
                        ? (aM[msb] != bM[msb]) && (res[msb] != aM[msb])
                        : (aM[msb] == bM[msb]) && (res[msb] != aM[msb]);
                    ccrWdata[BIT_CARRY] = sum[msb + 1];
                    state_next.result   = res;
                end
                OP_LOGIC:
                begin
                    ccrWe    = 1'b1;
                    ccrWdata[BIT_NEG]   = operandA[msb];
                    ccrWdata[BIT_ZERO]  = (operandA & maskOf(opSize)) == 32'h0000_0000;
                    ccrWdata[BIT_OVF]   = 1'b0;
                    state_next.result   = operandA & maskOf(opSize);
                end
                OP_SHIFT:
                begin
                    ccrWe    = 1'b1;
                    ccrWdata[BIT_NEG]   = operandA[msb];
                    ccrWdata[BIT_ZERO]  = (operandA & maskOf(opSize)) == 32'h0000_0000;
                    ccrWdata[BIT_OVF]   = 1'b0;
                    ccrWdata[BIT_CARRY] = shiftOut;
                    state_next.result   = operandA & maskOf(opSize);
                end
                OP_BLD:
                begin
                    ccrWe = 1'b1;
                    ccrWdata[BIT_CARRY] = selBit;
                end
                OP_BAND:
                begin
                    ccrWe = 1'b1;
                    ccrWdata[BIT_CARRY] = ccrQ[BIT_CARRY] & selBit;
                end
                OP_BOR:
                begin
                    ccrWe = 1'b1;
                    ccrWdata[BIT_CARRY] = ccrQ[BIT_CARRY] | selBit;
                end
                OP_BXOR:
                begin
                    ccrWe = 1'b1;
                    ccrWdata[BIT_CARRY] = ccrQ[BIT_CARRY] ^ selBit;
                end
                OP_LDC:
                begin
                    ccrWe = 1'b1;
                    ccrWdata = immData;
                end
                OP_AND_CONTROL_INSTRUCTION:
                begin
                    ccrWe = 1'b1;
                    ccrWdata = ccrQ & immData;
                end
                OP_ORC:
                begin
                    ccrWe = 1'b1;
                    ccrWdata = ccrQ | immData;
                end
                OP_XOR_CONTROL_INSTRUCTION:
                begin
                    ccrWe = 1'b1;
                    ccrWdata = ccrQ ^ immData;
                end
                OP_DECADJ:
                begin
                    ccrWe = 1'b1;
                    ccrWdata[BIT_NEG]   = adj[7];
                    ccrWdata[BIT_ZERO]  = adj == 8'h00;
                    ccrWdata[BIT_CARRY] = useExtend ? ccrQ[BIT_CARRY]
                        : (ccrQ[BIT_CARRY] || operandA[7:0] > 8'h99);
                    state_next.result   = {24'h00_0000, adj};
                end
                OP_NONE:
                    ccrWe = 1'b0;
                default:
                    ccrWe = 1'b0;
            endcase
        end
        // Exception entry wins over the mask bit of a flag update in the same cycle; other flag bits keep the update
        if (excStart)
        begin
            ccrWe = 1'b1;
            ccrWdata[BIT_MASK] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg       <= '0;
            state_reg.phase <= ST_RESET;
            state_reg.busy  <= 1'b1;
        end
        else
            state_reg <= state_next;
    end

    assign resultData  = state_reg.result;
    assign storeData   = state_reg.store;
    assign branchTaken = state_reg.taken;
    assign irqAccept   = state_reg.irqOk;
    assign busDataAddr = state_reg.dAddr;
    assign fetchAddr   = state_reg.pc;
    assign resetBusy   = state_reg.busy;

    // ************
    // Checks
    // ************
    sequence excSeq;
        excStart;
    endsequence

    masked_irq_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (irqReq && !nmiReq && ccrQ[BIT_MASK]) |=> !irqAccept)
        else $error("masked interrupt accepted");
    nmi_accept_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        nmiReq |=> irqAccept)
        else $error("nmi not accepted");
    exc_mask_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        excSeq |=> ccrQ[BIT_MASK])
        else $error("mask not set on exception");
    data_even_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        dataWide |=> !busDataAddr[0])
        else $error("wide data address odd");
    fetch_even_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !fetchAddr[0])
        else $error("fetch address odd");
    neg_sign_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state_reg.phase == ST_RUN && !excStart && opCode == OP_ADD && opSize == SZ_BYTE)
        |=> ccrQ[BIT_NEG] == resultData[7])
        else $error("negative flag not sign");
    carry_acc_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state_reg.phase == ST_RUN && !excStart && opCode == OP_BLD)
        |=> ccrQ[BIT_CARRY] == $past(selBit))
        else $error("bit load missed carry");
    ldc_load_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state_reg.phase == ST_RUN && !excStart && opCode == OP_LDC)
        |=> ccrQ == $past(immData))
        else $error("flag load failed");
    vector_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state_reg.phase == ST_VECTOR && vectorValid) |=> (!resetBusy ##0
        fetchAddr == {$past(vectorAddr[PC_WIDTH-1:1]), 1'b0}))
        else $error("start address not loaded");
    reset_mask_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state_reg.phase == ST_RESET) |-> (ccrQ[BIT_MASK] && !exrQ[EXR_BIT_TRACE]))
        else $error("reset values wrong");
endmodule // cpu_condition_flags

/* core/flag_store.sv */
// Small register holding the eight flag bits and the control register.
// Assumes the owner computes the next values; read data is registered.
module flag_store
    import ccr_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 arst_n,
    input  wire logic                 ccrWe,
    input  wire logic [CCR_WIDTH-1:0] ccrWdata,
    input  wire logic                 exrWe,
    input  wire logic [CCR_WIDTH-1:0] exrWdata,
    output logic      [CCR_WIDTH-1:0] ccrQ,
    output logic      [CCR_WIDTH-1:0] exrQ
);
    logic                 mask_reg;
    logic [BIT_MASK-1:0]  low_reg;

    // Split so each flip-flop group has a single process driving it
    assign ccrQ = {mask_reg, low_reg};

    // Mask and the whole control register (trace, reserved and mask bits) get reset values; other flags stay as they are
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mask_reg <= MASK_RESET;
            exrQ     <= {TRACE_RESET, EXR_RSVD, EXR_MASK_RESET};
        end
        else
        begin
            if (ccrWe)
                mask_reg <= ccrWdata[BIT_MASK];
            if (exrWe)
                exrQ <= {exrWdata[EXR_BIT_TRACE], EXR_RSVD, exrWdata[2:0]};
        end
    end

    // Undefined after reset, so no reset branch
    always_ff @(posedge clk_sys)
    begin
        if (ccrWe)
            low_reg <= ccrWdata[BIT_MASK-1:0];
    end
endmodule // flag_store

/* tb/tb_top.sv */
// Self-checking bench for the flag, branch, interrupt and alignment block.
// Assumes the vector model supplies the start address after reset.
module tb_top
    import ccr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [PC_WIDTH-1:0] START = 24'h001235;
    logic                  clk_sys = 1'b0;
    logic                  arst_n = 1'b0;
    op_type                opCode = OP_NONE;
    size_type              opSize = SZ_BYTE;
    logic [31:0]           operandA = '0, operandB = '0, resultData, r;
    logic                  useExtend = 0, shiftOut = 0, bitInvert = 0, storeReq = 0;
    logic [2:0]            bitIndex = '0;
    logic [7:0]            immData = '0, storeData, f;
    logic [3:0]            branchCond = '0;
    logic                  irqReq = 0, nmiReq = 0, excStart = 0, pcLoad = 0;
    logic                  dataWide = 0, vectorValid, branchTaken, irqAccept, resetBusy;
    logic [PC_WIDTH-1:0]   pcNext = '0, vectorAddr, fetchAddr;
    logic [ADDR_WIDTH-1:0] dataAddr = '0, busDataAddr;
    int                    miscompares = 0, nTests = 0;

    initial forever #5 clk_sys = ~clk_sys;

    cpu_condition_flags i_cpu_condition_flags (.clk_sys, .arst_n, .opCode, .opSize,
        .operandA, .operandB, .useExtend, .shiftOut, .bitIndex, .bitInvert, .immData,
        .storeReq, .branchCond, .irqReq, .nmiReq, .excStart, .vectorAddr, .vectorValid,
        .pcNext, .pcLoad, .dataAddr, .dataWide, .resultData, .storeData, .branchTaken,
        .irqAccept, .busDataAddr, .fetchAddr, .resetBusy);
    vector_model #(.DELAY(5), .START(START)) i_vector_model (.clk_sys, .resetBusy,
        .vectorAddr, .vectorValid);

    // ************
    // Shared tasks
    // ************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        nTests++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Op in one cycle, flags captured the next, read one edge later
    task automatic doOp(input op_type o, input size_type s, input logic [31:0] a, b);
        @(negedge clk_sys);
        opCode = o;
        opSize = s;
        operandA = a;
        operandB = b;
        immData = a[7:0];
        @(negedge clk_sys);
        opCode = OP_NONE;
        storeReq = 1'b1;
        r = resultData;
        @(negedge clk_sys);
        storeReq = 1'b0;
        f = storeData;
    endtask

    task automatic arith(input op_type o, input size_type s, input logic [31:0] a, b, e,
                         input logic [7:0] ef);
        doOp(o, s, a, b);
        chk("result", e, r & (s == SZ_BYTE ? 32'h000000ff :
                              s == SZ_WORD ? 32'h0000ffff : 32'hffffffff));
        chk("flags", {24'h0, ef}, {24'h0, f & 8'h2f});
    endtask

    task automatic br(input logic [3:0] c, input logic e);
        @(negedge clk_sys);
        branchCond = c;
        @(negedge clk_sys);
        chk("branch", {31'h0, e}, {31'h0, branchTaken});
    endtask

    task automatic irq(input logic i, n, e);
        @(negedge clk_sys);
        irqReq = i;
        nmiReq = n;
        @(negedge clk_sys);
        chk("irq", {31'h0, e}, {31'h0, irqAccept});
        irqReq = 1'b0;
        nmiReq = 1'b0;
    endtask

    // ************
    // Scenarios
    // ************
    task automatic testReset();
        chk("busy", 32'h1, {31'h0, resetBusy});
        @(negedge clk_sys);
        arst_n = 1'b1;
        for (int i = 0; i < 50 && resetBusy !== 1'b0; i++) @(negedge clk_sys);
        chk("vector", {8'h0, START & 24'hfffffe}, {8'h0, fetchAddr});
        // First op only once the start address is in, as software would
        // set up its stack before any use
        doOp(OP_LDC, SZ_BYTE, 32'h80, 0);
        doOp(OP_NONE, SZ_BYTE, 0, 0);
        chk("mask", 32'h1, {31'h0, f[BIT_MASK]});
    endtask

    task automatic testArith();
        doOp(OP_LDC, SZ_BYTE, 0, 0);
        arith(OP_ADD, SZ_BYTE, 32'h0f, 32'h01, 32'h10, 8'h20);
        arith(OP_ADD, SZ_BYTE, 32'h7f, 32'h01, 32'h80, 8'h2a);
        arith(OP_ADD, SZ_BYTE, 32'hff, 32'h01, 32'h00, 8'h25);
        arith(OP_ADD, SZ_WORD, 32'h0fff, 32'h1, 32'h1000, 8'h20);
        arith(OP_ADD, SZ_LONG, 32'h0fffffff, 32'h1, 32'h10000000, 8'h20);
        arith(OP_SUB, SZ_BYTE, 32'h10, 32'h01, 32'h0f, 8'h20);
        arith(OP_SUB, SZ_BYTE, 32'h00, 32'h01, 32'hff, 8'h29);
        arith(OP_SUB, SZ_WORD, 32'h8000, 32'h1, 32'h7fff, 8'h22);
        arith(OP_NEG, SZ_BYTE, 32'h0, 32'h01, 32'hff, 8'h29);
        arith(OP_NEG, SZ_LONG, 32'h0, 32'h1, 32'hffffffff, 8'h29);
        doOp(OP_LDC, SZ_BYTE, 0, 0);
        doOp(OP_DECADJ, SZ_BYTE, 32'h0a, 0);
        chk("decimal", 32'h10, r & 32'hff);
        doOp(OP_LDC, SZ_BYTE, 32'h01, 0);
        useExtend = 1'b1;
        arith(OP_ADD, SZ_BYTE, 32'h0e, 32'h01, 32'h10, 8'h20);
        doOp(OP_LDC, SZ_BYTE, 32'h20, 0);
        doOp(OP_DECADJ, SZ_BYTE, 32'h1b, 0);
        chk("decimal sub", 32'h15, r & 32'hff);
        useExtend = 1'b0;
    endtask

    task automatic testControl();
        doOp(OP_LDC, SZ_BYTE, 32'h00, 0);
        chk("load", 32'h00, {24'h0, f});
        doOp(OP_ORC, SZ_BYTE, 32'h85, 0);
        chk("or", 32'h85, {24'h0, f});
        doOp(OP_AND_CONTROL_INSTRUCTION, SZ_BYTE, 32'h0f, 0);
        chk("and", 32'h05, {24'h0, f});
        doOp(OP_XOR_CONTROL_INSTRUCTION, SZ_BYTE, 32'hff, 0);
        chk("xor", 32'hfa, {24'h0, f});
    endtask

    task automatic testBranch();
        doOp(OP_LDC, SZ_BYTE, 32'h04, 0);
        br(4'h7, 1'b1);
        br(4'h6, 1'b0);
        br(4'h0, 1'b1);
        br(4'h1, 1'b0);
        doOp(OP_LDC, SZ_BYTE, 32'h01, 0);
        br(4'h5, 1'b1);
        br(4'h4, 1'b0);
        doOp(OP_LDC, SZ_BYTE, 32'h0a, 0);
        br(4'hb, 1'b1);
        br(4'h9, 1'b1);
        br(4'h8, 1'b0);
    endtask

    task automatic testIrq();
        doOp(OP_LDC, SZ_BYTE, 32'h80, 0);
        irq(1'b1, 1'b0, 1'b0);
        irq(1'b0, 1'b1, 1'b1);
        doOp(OP_LDC, SZ_BYTE, 32'h00, 0);
        irq(1'b1, 1'b0, 1'b1);
        @(negedge clk_sys);
        excStart = 1'b1;
        @(negedge clk_sys);
        excStart = 1'b0;
        doOp(OP_NONE, SZ_BYTE, 0, 0);
        chk("entry mask", 32'h1, {31'h0, f[BIT_MASK]});
        irq(1'b1, 1'b0, 1'b0);
    endtask

    task automatic testBits();
        shiftOut = 1'b1;
        doOp(OP_SHIFT, SZ_BYTE, 32'h02, 0);
        chk("shift carry", 32'h1, {31'h0, f[BIT_CARRY]});
        shiftOut = 1'b0;
        bitIndex = 3'h7;
        doOp(OP_BLD, SZ_BYTE, 32'h7f, 0);
        chk("bit load", 32'h0, {31'h0, f[BIT_CARRY]});
        bitIndex = 3'h0;
        bitInvert = 1'b1;
        doOp(OP_BLD, SZ_BYTE, 32'hfe, 0);
        chk("bit inv", 32'h1, {31'h0, f[BIT_CARRY]});
        bitInvert = 1'b0;
    endtask

    task automatic testAlign();
        @(negedge clk_sys);
        dataWide = 1'b1;
        dataAddr = 32'h00001235;
        pcNext = 24'h000ab1;
        pcLoad = 1'b1;
        @(negedge clk_sys);
        pcLoad = 1'b0;
        chk("wide addr", 32'h00001234, busDataAddr);
        chk("fetch", 32'h000ab0, {8'h0, fetchAddr});
        dataWide = 1'b0;
        @(negedge clk_sys);
        chk("byte addr", 32'h00001235, busDataAddr);
    endtask

    task automatic results();
        $display("Comparisons %0d mismatches %0d", nTests, miscompares);
        if (miscompares == 0 && nTests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge clk_sys);
        testReset();
        testArith();
        testControl();
        testBranch();
        testIrq();
        testBits();
        testAlign();
        results();
    end

    initial
    begin
        #50000;
        miscompares++;
        results();
    end
endmodule // tb_top

/* tb/vector_model.sv */
// Model of the reset-vector source behind the CPU flag block.
// Assumes resetBusy is sampled on falling edges of clk_sys.
module vector_model
    import ccr_pkg::*;
#(
    parameter int                  DELAY = 3,
    parameter logic [PC_WIDTH-1:0] START = 24'h001235
)
(
    input  wire logic                clk_sys,
    input  wire logic                resetBusy,
    output logic     [PC_WIDTH-1:0]  vectorAddr,
    output logic                     vectorValid
);
    timeunit 1ns;
    timeprecision 1ns;
    int waitCnt = 0;
    initial vectorValid = 1'b0;
    initial vectorAddr = ~START;
    // Invalid address toggles so a stale value is never mistaken for data
    always @(negedge clk_sys)
    begin
        waitCnt <= resetBusy ? waitCnt + 1 : 0;
        vectorValid <= resetBusy && waitCnt >= DELAY;
        vectorAddr <= (resetBusy && waitCnt >= DELAY) ? START : ~vectorAddr;
    end
endmodule // vector_model
